// *** sdic_map.vh ***
`ifndef SDIC_MAP_VH
`define SDIC_MAP_VH
// Register byte offsets on the Avalon-MM slave
`define SDIC_REG_CMD 5'h00
`define SDIC_REG_OPND 5'h04
`define SDIC_REG_VALUE 5'h08
`define SDIC_REG_STATUS 5'h0C
`define SDIC_REG_SETUP 5'h10
`define SDIC_REG_CTL 5'h14
// Command codes in CMD[7:0]; draw opcode sits in CMD[15:8]
`define SDIC_CMD_WR_CTL 8'h01
`define SDIC_CMD_STEP_CNT 8'h02
`define SDIC_CMD_STEP_X 8'h03
`define SDIC_CMD_STEP_Q 8'h04
`define SDIC_CMD_DRAW 8'h05
// Instruction opcodes driven to the device
`define SDIC_OP_CTL_WR 8'h01
`define SDIC_OP_STEP_X 8'hD0
`define SDIC_OP_STEP_Q 8'hD1
`define SDIC_OP_STEP_CNT 8'hD7
// SETUP fields
`define SDIC_SET_DIR 0
`define SDIC_SET_PAT_EN 1
`define SDIC_SET_PSIZE_LO 2
`define SDIC_SET_SRC_EN 4
`define SDIC_SET_SWAP_CLR 5
`define SDIC_SET_MASK_ONES 6
`define SDIC_SET_LIMIT_OFF 7
`define SDIC_SET_PWIDTH_LO 8
// Reset values
`define SDIC_SETUP_RST 32'h0000_0000
`define SDIC_CTL_RST 16'h0000
// Iteration control value that selects triangle shadowing
`define SDIC_CTL_SHADOW 4'hB
// Source U delta for each horizontal direction
`define SDIC_DU_LTR 32'h0000_0000
`define SDIC_DU_RTL 32'hFFF8_0000
// Hazard gaps in instruction slots
`define SDIC_GAP_CTL 2'h3
`define SDIC_GAP_CNT 2'h1
`define SDIC_GAP_X 2'h1
// Error codes reported in STATUS[7:4]
`define SDIC_ERR_NONE 4'h0
`define SDIC_ERR_OPCODE 4'h1
`define SDIC_ERR_ALIGN 4'h2
`define SDIC_ERR_SHADOW 4'h3
`define SDIC_ERR_SLOT 4'h4
`define SDIC_ERR_PERSP 4'h5
`define SDIC_ERR_PSETUP 4'h6
`define SDIC_ERR_PATTERN 4'h7
`define SDIC_ERR_CMD 4'h8
`endif

// *** sdic_draw_check.v ***
`timescale 1ns/10ps
`include "sdic_map.vh"
// Combinational legality check of one draw order
module sdic_draw_check
(
   input wire [7:0] i_opcode,
   input wire [7:0] i_dst,
   input wire [7:0] i_psrc,
   input wire [7:0] i_dsrc,
   input wire [15:0] i_ctl,
   input wire [31:0] i_setup,
   input wire i_seed_ok,
   output reg [3:0] o_err,
   output reg o_parallel,
   output reg o_persp
);
   // Alignment mask from number of register-file locations
   function [7:0] align_mask;
      input [3:0] locs;
      begin
         if (locs <= 4'h2)
            align_mask = 8'h01;
         else if (locs <= 4'h4)
            align_mask = 8'h03;
         else if (locs <= 4'h8)
            align_mask = 8'h07;
         else
            align_mask = 8'h0F;
      end
   endfunction
   // Colour presence {r,g,b} per slot; intensity counts as all three
   function [2:0] slot_rgb;
      input [1:0] slot;
      input [4:0] code;
      begin
         slot_rgb = 3'h0;
         case (slot)
            2'h0: if (code == 5'h06 || code == 5'h07) slot_rgb = 3'h4;
            2'h1:
            begin
               if (code == 5'h0A || (code >= 5'h16 && code <= 5'h19)) slot_rgb = 3'h4;
               else if (code == 5'h10) slot_rgb = 3'h3;
               else if (code == 5'h0C || code == 5'h1C) slot_rgb = 3'h7;
            end
            2'h2:
            begin
               if (code == 5'h00) slot_rgb = 3'h3;
               else if (code >= 5'h06 && code <= 5'h09) slot_rgb = 3'h4;
               else if (code >= 5'h0C && code <= 5'h0F) slot_rgb = 3'h7;
            end
            default:
            begin
               if (code == 5'h00) slot_rgb = 3'h3;
               else if (code == 5'h06 || code == 5'h07) slot_rgb = 3'h4;
            end
         endcase
      end
   endfunction
   reg [2:0] pairs; // Parameter pairs of the opcode, 0 for parallel
   reg known; // Opcode is a draw
   reg [7:0] mask;
   reg [2:0] rgb;
   reg bad_slot;
   reg [2:0] psize;
   reg [7:0] min_width;
   // Decode and check
   always @*
   begin
      pairs = 3'h0;
      known = 1'b1;
      o_parallel = 1'b0;
      case (i_opcode)
         8'hE0, 8'hE1, 8'hE4, 8'hE5: o_parallel = 1'b1;
         8'hF0, 8'hF1: pairs = 3'h1;
         8'hF2, 8'hF3: pairs = 3'h2;
         8'hF8, 8'hF9: pairs = 3'h3;
         8'hFA, 8'hFB: pairs = 3'h4;
         8'hFC, 8'hFD: pairs = 3'h5;
         default: known = 1'b0;
      endcase
      // Parallel draws use two locations
      mask = align_mask(o_parallel ? 4'h2 : {pairs, 1'b0});
      // Reserved and not-applicable slot codes
      bad_slot = (i_ctl[3:0] == 4'hB)
         || (pairs >= 3'h3 && i_ctl[12:9] == 4'h5)
         || (pairs >= 3'h4 && i_ctl[15:13] == 3'h5);
      rgb = slot_rgb(2'h0, {1'b0, i_ctl[3:0]});
      if (pairs >= 3'h2) rgb = rgb | slot_rgb(2'h1, i_ctl[8:4]);
      if (pairs >= 3'h3) rgb = rgb | slot_rgb(2'h2, {1'b0, i_ctl[12:9]});
      if (pairs >= 3'h4) rgb = rgb | slot_rgb(2'h3, {2'h0, i_ctl[15:13]});
      if (pairs == 3'h5) rgb = rgb | 3'h3;
      // Partial colour iteration is refused
      if (rgb != 3'h0 && rgb != 3'h7) bad_slot = 1'b1;
      // Odd slot-zero codes carry Q
      o_persp = !o_parallel && known && i_ctl[0];
      psize = 3'h1 << i_setup[`SDIC_SET_PSIZE_LO +: 2];
      min_width = 8'h08 >> i_setup[`SDIC_SET_PSIZE_LO +: 2];
      o_err = `SDIC_ERR_NONE;
      if (!known || psize == 3'h0)
         o_err = `SDIC_ERR_OPCODE;
      else if (((i_dst | i_psrc | i_dsrc) & mask) != 8'h00)
         o_err = `SDIC_ERR_ALIGN;
      else if (!o_parallel && i_ctl[3:0] == `SDIC_CTL_SHADOW)
         o_err = `SDIC_ERR_SHADOW;
      else if (!o_parallel && bad_slot)
         o_err = `SDIC_ERR_SLOT;
      else if (o_persp && (pairs < 3'h2 || !i_seed_ok))
         o_err = `SDIC_ERR_PERSP;
      else if (o_parallel && (!i_setup[`SDIC_SET_SWAP_CLR]
         || !i_setup[`SDIC_SET_MASK_ONES] || !i_setup[`SDIC_SET_LIMIT_OFF]))
         o_err = `SDIC_ERR_PSETUP;
      else if (o_parallel && i_setup[`SDIC_SET_PAT_EN] && (i_setup[`SDIC_SET_DIR]
         || i_setup[`SDIC_SET_PWIDTH_LO +: 8] < min_width))
         o_err = `SDIC_ERR_PATTERN;
   end
endmodule // sdic_draw_check

// *** sdic_issue_ctrl.v ***
// Behaviour
// - Three slots after control write before draws
// - No parameterized draw under shadowing setting
// - Operands aligned to locations used
// - Changed pixel state stepped before the draw
// - Direction picks source U delta value
// - One slot after length or X writes
// - Parallel setup: swap clear, masks, limits off
// - Patterned parallel only left-to-right, wide pattern
// - Red, green, blue iterate together only
// - Perspective draws need two pairs, seed step
`timescale 1ns/10ps
`include "sdic_map.vh"
module sdic_issue_ctrl
(
   input wire i_sys_clk,
   input wire i_sys_rst,
   // Avalon-MM slave
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   // Instruction port towards the draw unit
   output reg o_ins_valid,
   output reg [7:0] o_ins_opcode,
   output reg [7:0] o_ins_dst,
   output reg [7:0] o_ins_psrc,
   output reg [7:0] o_ins_dsrc,
   output reg [31:0] o_ins_value,
   output reg [31:0] o_ins_src_u_delta,
   input wire i_ins_stall
);
   // Sequencer states
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_CHECK = 2'h1;
   localparam [1:0] ST_WAIT = 2'h2;
   localparam [1:0] ST_ISSUE = 2'h3;

   reg [1:0] state_ff; // Sequencer state
   reg [1:0] nxt_state;
   reg [7:0] cmd_ff; // Latched command code
   reg [7:0] op_ff; // Latched draw opcode
   reg [31:0] opnd_ff; // Operand indices
   reg [31:0] value_ff; // Value for steps and control writes
   reg [31:0] setup_ff; // Parallel draw setup and pixel size
   reg [15:0] ctl_ff; // Mirror of the iteration control register
   reg [3:0] err_ff; // Last refusal cause
   reg seed_ok_ff; // Q seed step issued since last perspective draw
   reg [1:0] ctl_gap_ff; // Slots left after a control write
   reg [1:0] cnt_gap_ff; // Slots left after a length step
   reg [1:0] x_gap_ff; // Slots left after an X step
   reg [15:0] issued_ff; // Accepted instruction count
   reg rd_done_ff; // Read answer phase
   wire [3:0] chk_err;
   wire chk_parallel;
   wire chk_persp;
   wire cmd_wr; // Software write to the command register
   wire accept; // Device takes the instruction this edge
   wire gap_clear; // All hazards relevant to the pending order passed
   wire busy;

   assign busy = (state_ff != ST_IDLE);
   assign cmd_wr = i_avs_write && (i_avs_address == `SDIC_REG_CMD);
   assign accept = o_ins_valid && !i_ins_stall;
   // Command writes wait while an order is in flight; reads take one wait cycle
   assign o_avs_waitrequest = (i_avs_read && !rd_done_ff) || (cmd_wr && busy);

   // Legality of the pending draw order
   sdic_draw_check u_check
   (
      .i_opcode(op_ff),
      .i_dst(opnd_ff[7:0]),
      .i_psrc(opnd_ff[15:8]),
      .i_dsrc(opnd_ff[23:16]),
      .i_ctl(ctl_ff),
      .i_setup(setup_ff),
      .i_seed_ok(seed_ok_ff),
      .o_err(chk_err),
      .o_parallel(chk_parallel),
      .o_persp(chk_persp)
   );

   // Draws wait out control and length hazards; X matters only for parallel
   assign gap_clear = (cmd_ff != `SDIC_CMD_DRAW) ||
      ((ctl_gap_ff == 2'h0) && (cnt_gap_ff == 2'h0)
      && (!chk_parallel || x_gap_ff == 2'h0));

   // Next-state logic
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (cmd_wr)
               nxt_state = ST_CHECK;
         ST_CHECK:
            if ((cmd_ff == `SDIC_CMD_DRAW && chk_err != `SDIC_ERR_NONE)
               || cmd_ff == 8'h00 || cmd_ff > `SDIC_CMD_DRAW)
               nxt_state = ST_IDLE;
            else
               nxt_state = ST_WAIT;
         ST_WAIT:
            if (gap_clear)
               nxt_state = ST_ISSUE;
         default:
            // Hold the instruction until the device stops stalling
            if (accept)
               nxt_state = ST_IDLE;
      endcase
   end

   // Sequencer and command latches
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_ff <= ST_IDLE;
         cmd_ff <= 8'h00;
         op_ff <= 8'h00;
         err_ff <= `SDIC_ERR_NONE;
      end
      else
      begin
         state_ff <= nxt_state;
         if (state_ff == ST_IDLE && cmd_wr)
         begin
            cmd_ff <= i_avs_writedata[7:0];
            op_ff <= i_avs_writedata[15:8];
         end
         // Refusals are reported, valid orders clear the cause
         if (state_ff == ST_CHECK)
         begin
            if (cmd_ff == 8'h00 || cmd_ff > `SDIC_CMD_DRAW)
               err_ff <= `SDIC_ERR_CMD;
            else if (cmd_ff == `SDIC_CMD_DRAW)
               err_ff <= chk_err;
            else
               err_ff <= `SDIC_ERR_NONE;
         end
      end
   end

   // Software-written registers; operands locked while busy
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         opnd_ff <= 32'h0000_0000;
         value_ff <= 32'h0000_0000;
         setup_ff <= `SDIC_SETUP_RST;
      end
      else if (i_avs_write && !busy)
      begin
         if (i_avs_address == `SDIC_REG_OPND)
            opnd_ff <= i_avs_writedata;
         else if (i_avs_address == `SDIC_REG_VALUE)
            value_ff <= i_avs_writedata;
         else if (i_avs_address == `SDIC_REG_SETUP)
            setup_ff <= i_avs_writedata;
      end
   end

   // Instruction port drive; data outputs are registered
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_ins_valid <= 1'b0;
         o_ins_opcode <= 8'h00;
         o_ins_dst <= 8'h00;
         o_ins_psrc <= 8'h00;
         o_ins_dsrc <= 8'h00;
         o_ins_value <= 32'h0000_0000;
         o_ins_src_u_delta <= `SDIC_DU_LTR;
      end
      else if (state_ff == ST_WAIT && gap_clear)
      begin
         o_ins_valid <= 1'b1;
         o_ins_dst <= opnd_ff[7:0];
         o_ins_psrc <= opnd_ff[15:8];
         o_ins_dsrc <= opnd_ff[23:16];
         // Step value carries the length in its upper half
         o_ins_value <= value_ff;
         case (cmd_ff)
            `SDIC_CMD_WR_CTL: o_ins_opcode <= `SDIC_OP_CTL_WR;
            `SDIC_CMD_STEP_CNT: o_ins_opcode <= `SDIC_OP_STEP_CNT;
            // Steps are issued and taken before any later draw is checked
            `SDIC_CMD_STEP_X: o_ins_opcode <= `SDIC_OP_STEP_X;
            `SDIC_CMD_STEP_Q: o_ins_opcode <= `SDIC_OP_STEP_Q;
            default: o_ins_opcode <= op_ff;
         endcase
         // Source U delta follows the horizontal direction flag on parallel draws with source enabled, else left-to-right
         if (chk_parallel && setup_ff[`SDIC_SET_SRC_EN] && setup_ff[`SDIC_SET_DIR])
            o_ins_src_u_delta <= `SDIC_DU_RTL;
         else
            o_ins_src_u_delta <= `SDIC_DU_LTR;
      end
      else if (accept)
         o_ins_valid <= 1'b0;
   end

   // Hazard slot counters; a fresh write reloads, otherwise count down
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ctl_gap_ff <= 2'h0;
         cnt_gap_ff <= 2'h0;
         x_gap_ff <= 2'h0;
      end
      else
      begin
         if (accept && o_ins_opcode == `SDIC_OP_CTL_WR)
            ctl_gap_ff <= `SDIC_GAP_CTL;
         else if (ctl_gap_ff != 2'h0)
            ctl_gap_ff <= ctl_gap_ff - 2'h1;
         if (accept && o_ins_opcode == `SDIC_OP_STEP_CNT)
            cnt_gap_ff <= `SDIC_GAP_CNT;
         else if (cnt_gap_ff != 2'h0)
            cnt_gap_ff <= cnt_gap_ff - 2'h1;
         if (accept && o_ins_opcode == `SDIC_OP_STEP_X)
            x_gap_ff <= `SDIC_GAP_X;
         else if (x_gap_ff != 2'h0)
            x_gap_ff <= x_gap_ff - 2'h1;
      end
   end

   // Control mirror, seed tracking and issue count
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ctl_ff <= `SDIC_CTL_RST;
         seed_ok_ff <= 1'b0;
         issued_ff <= 16'h0000;
      end
      else
      begin
         // Mirror updates only when the device takes the write
         if (accept && o_ins_opcode == `SDIC_OP_CTL_WR)
            ctl_ff <= o_ins_value[15:0];
         // Seed step sets; perspective draw consumes; set wins
         if (accept && o_ins_opcode == `SDIC_OP_STEP_Q)
            seed_ok_ff <= 1'b1;
         else if (accept && chk_persp && cmd_ff == `SDIC_CMD_DRAW)
            seed_ok_ff <= 1'b0;
         if (accept)
            issued_ff <= issued_ff + 16'h0001;
      end
   end

   // Read path: data registered, answered on the second edge
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rd_done_ff <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         rd_done_ff <= i_avs_read && !rd_done_ff;
         if (i_avs_read && !rd_done_ff)
         begin
            if (i_avs_address == `SDIC_REG_CMD)
               o_avs_readdata <= {16'h0000, op_ff, cmd_ff};
            else if (i_avs_address == `SDIC_REG_OPND)
               o_avs_readdata <= opnd_ff;
            else if (i_avs_address == `SDIC_REG_VALUE)
               o_avs_readdata <= value_ff;
            else if (i_avs_address == `SDIC_REG_STATUS)
               o_avs_readdata <= {issued_ff, 7'h00, seed_ok_ff, err_ff, 3'h0, busy};
            else if (i_avs_address == `SDIC_REG_SETUP)
               o_avs_readdata <= setup_ff;
            else if (i_avs_address == `SDIC_REG_CTL)
               o_avs_readdata <= {16'h0000, ctl_ff};
            else
               // Unmapped addresses read zero
               o_avs_readdata <= 32'h0000_0000;
         end
      end
   end
endmodule // sdic_issue_ctrl

// *** sdic_issue_ctrl_assertions.sv ***
`timescale 1ns/10ps
// Protocol watch on the instruction port of the issue controller
module sdic_issue_assertions
(
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire o_ins_valid,
   input wire [7:0] o_ins_opcode,
   input wire [7:0] o_ins_dst,
   input wire [7:0] o_ins_psrc,
   input wire [7:0] o_ins_dsrc,
   input wire [31:0] o_ins_value,
   input wire [31:0] o_ins_src_u_delta,
   input wire i_ins_stall
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // Taken, any draw, parameterized draw
   wire tk = o_ins_valid && !i_ins_stall;
   wire drw = o_ins_valid && (o_ins_opcode[7:5] == 3'h7);
   wire pdrw = o_ins_valid && (o_ins_opcode[7:4] == 4'hF);
   // Alignment mask from register locations used
   wire [7:0] am = (o_ins_opcode[7:4] == 4'hE || o_ins_opcode[7:1] == 7'h78) ? 8'h01 :
      (o_ins_opcode[7:1] == 7'h79) ? 8'h03 : (o_ins_opcode[7:2] == 6'h3E) ? 8'h07 : 8'h0F;
   reg [15:0] ctl_ff; // Control value as seen by the device
   reg seed_ff; // Q seed step seen, not yet consumed
   // Shadow of what the device was told; only taken words count
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ctl_ff <= 16'h0000;
         seed_ff <= 1'b0;
      end
      else
      begin
         if (tk && o_ins_opcode == 8'h01)
            ctl_ff <= o_ins_value[15:0];
         if (tk && o_ins_opcode == 8'hD1)
            seed_ff <= 1'b1;
         else if (tk && pdrw && ctl_ff[0])
            seed_ff <= 1'b0;
      end
   end
   sequence s_ctl_tk;
      tk && o_ins_opcode == 8'h01;
   endsequence
   sequence s_cnt_tk;
      tk && o_ins_opcode == 8'hD7;
   endsequence
   sequence s_x_tk;
      tk && o_ins_opcode == 8'hD0;
   endsequence
   a_ctl_gap: assert property (s_ctl_tk |=> !drw [*3])
      else $error("draw offered within three slots of control write");
   a_cnt_gap: assert property (s_cnt_tk |=> !drw)
      else $error("draw offered right after count step");
   a_x_gap: assert property
      (s_x_tk |=> !(drw && o_ins_opcode[7:4] == 4'hE))
      else $error("parallel draw offered right after x step");
   a_no_shadow: assert property (pdrw |-> ctl_ff[3:0] != 4'hB)
      else $error("parameterized draw under shadowing setting");
   a_operand_align: assert property
      (drw |-> ((o_ins_dst | o_ins_psrc | o_ins_dsrc) & am) == 8'h00)
      else $error("draw operand misaligned");
   a_du_value: assert property
      (drw |-> o_ins_src_u_delta == 32'h0 || o_ins_src_u_delta == 32'hFFF80000)
      else $error("source u delta not a legal value");
   a_stall_hold: assert property
      (o_ins_valid && i_ins_stall |=> o_ins_valid && $stable(o_ins_opcode)
      && $stable(o_ins_value))
      else $error("instruction changed while stalled");
   a_persp_seed: assert property
      (pdrw && ctl_ff[0] |-> seed_ff && o_ins_opcode[3:1] != 3'h0)
      else $error("perspective draw without seed or with one pair");
   a_slot_na: assert property
      (pdrw && o_ins_opcode[3] |-> ctl_ff[12:9] != 4'h5
      && (o_ins_opcode[2:1] == 2'h0 || ctl_ff[15:13] != 3'h5))
      else $error("draw uses a not applicable slot code");
endmodule // sdic_issue_assertions
bind sdic_issue_ctrl sdic_issue_assertions u_sdic_issue_assertions
(
   .i_sys_clk(i_sys_clk),
   .i_sys_rst(i_sys_rst),
   .o_ins_valid(o_ins_valid),
   .o_ins_opcode(o_ins_opcode),
   .o_ins_dst(o_ins_dst),
   .o_ins_psrc(o_ins_psrc),
   .o_ins_dsrc(o_ins_dsrc),
   .o_ins_value(o_ins_value),
   .o_ins_src_u_delta(o_ins_src_u_delta),
   .i_ins_stall(i_ins_stall)
);

// *** sdic_draw_unit_model.sv ***
`timescale 1ns/10ps
// Behavioural draw unit: control, length counter, stall timing
module sdic_draw_unit_model
(
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_valid,
   input wire [7:0] i_opcode,
   input wire [31:0] i_value,
   input wire [3:0] i_fill_wait,
   output wire o_stall,
   output reg [15:0] o_ctl,
   output reg [15:0] o_cnt,
   output reg [7:0] o_drawn
);
   reg seen_ff; // Current word already stalled once
   reg [7:0] wait_ff; // Stall cycles still owed
   wire par = i_opcode[7:4] == 4'hE;
   wire prm = i_opcode[7:4] == 4'hF;
   wire go = $signed(o_cnt) > 16'sh0000; // Signed for parameterized draws
   // Pair count from opcode
   wire [7:0] np = (i_opcode[3:1] == 3'h0) ? 8'h01 : (i_opcode[3:1] == 3'h1) ? 8'h02 :
      (i_opcode[3:1] == 3'h4) ? 8'h03 : (i_opcode[3:1] == 3'h5) ? 8'h04 : 8'h05;
   // Fill wait plus launch time; repeated draws also count pixels
   wire [7:0] need = !prm ? 8'h00 : {4'h0, i_fill_wait} + (i_opcode[0] ?
      8'h01 + (np << 1) + (go ? o_cnt[7:0] : 8'h00) : 8'h02);
   assign o_stall = i_valid && (seen_ff ? wait_ff != 8'h00 : need != 8'h00);
   // Execute a taken word, else count the stall down
   always @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         seen_ff <= 1'b0;
         wait_ff <= 8'h00;
         o_ctl <= 16'h0000;
         o_cnt <= 16'h0000;
         o_drawn <= 8'h00;
      end
      else if (i_valid && !o_stall)
      begin
         seen_ff <= 1'b0;
         if (i_opcode == 8'h01)
            o_ctl <= i_value[15:0];
         else if (i_opcode == 8'hD7)
            o_cnt <= i_value[31:16];
         else if (par && o_cnt != 16'h0000)
         begin
            o_drawn <= o_drawn + 8'h01;
            if (i_opcode == 8'hE1)
               o_cnt <= 16'h0000; // E1 clears it; the other parallel forms keep it
         end
         else if (prm && go)
         begin
            o_drawn <= o_drawn + 8'h01;
            if (i_opcode[0])
               o_cnt <= 16'h0000;
         end
      end
      else if (i_valid && !seen_ff)
      begin
         seen_ff <= 1'b1;
         wait_ff <= need - 8'h01;
      end
      else if (wait_ff != 8'h00)
         wait_ff <= wait_ff - 8'h01;
   end
endmodule // sdic_draw_unit_model

// *** sdic_issue_ctrl_tb.sv ***
`timescale 1ns/10ps
`include "sdic_map.vh"
module sdic_issue_ctrl_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [4:0] adr = 5'h00;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg [31:0] wd = 32'h0;
   reg [3:0] fw = 4'h0; // Fill engine busy cycles
   wire [31:0] rdata, val, du;
   wire wreq, valid, stall;
   wire [7:0] op, drawn;
   wire [15:0] mctl, mcnt;
   reg [31:0] q, n0;
   int err_total = 0, total_checks = 0, cyc = 0, t_ctl = -99, t_cnt = -99, st_n = 0, st_l = 0;
   reg [31:0] last_du;
   reg [7:0] dr0;
   initial
   begin
      forever #4 clk = ~clk;
   end
   sdic_issue_ctrl u_sdic_issue_ctrl (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .o_ins_valid(valid), .o_ins_opcode(op), .o_ins_dst(),
      .o_ins_psrc(), .o_ins_dsrc(), .o_ins_value(val), .o_ins_src_u_delta(du),
      .i_ins_stall(stall));
   sdic_draw_unit_model u_sdic_draw_unit_model (.i_sys_clk(clk), .i_sys_rst(rst), .i_valid(valid),
      .i_opcode(op), .i_value(val), .i_fill_wait(fw), .o_stall(stall), .o_ctl(mctl),
      .o_cnt(mcnt), .o_drawn(drawn));
   task chk(input string nm, input [31:0] e, input [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One Avalon transfer, held until waitrequest is seen low
   task av(input bit r, input [4:0] a, input [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      rd <= r;
      wr <= !r;
      // Request stands until an edge finds waitrequest low; data taken there
      do
         @(posedge clk);
      while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Poll until the controller reports idle; a hang ends at the timeout
   task idle;
      do
         av(1, `SDIC_REG_STATUS, 0);
      while (q[0] !== 1'b0);
   endtask
   task order(input [7:0] c, input [7:0] dop, input [31:0] v);
      av(0, `SDIC_REG_VALUE, v);
      av(0, `SDIC_REG_CMD, {16'h0, dop, c});
      idle;
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watch taken words: spacing and stall length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         wrap_up;
      end
      if ((valid & stall) === 1'b1)
         st_n++;
      if ((valid & ~stall) === 1'b1)
      begin
         last_du <= du;
         st_l <= st_n;
         st_n = 0;
         if (op == 8'h01)
            t_ctl <= cyc;
         if (op == 8'hD7)
            t_cnt <= cyc;
         if (op[7:5] == 3'h7)
            chk("draw spacing", 1, cyc - t_ctl > 3 && cyc - t_cnt > 1);
      end
   end
   // Refused orders: control, setup, operands, opcode, command, error
   reg [15:0] tc [0:8] = '{16'h10, 16'h10, 16'h10, 16'h10, 16'h10, 16'hB, 16'h1, 16'hA00, 16'h6};
   reg [31:0] ts [0:8] = '{32'h0, 32'hE0, 32'h10E3, 32'hE0, 32'hE0, 32'hE0, 32'hE0, 32'hE0, 32'hE0};
   reg [31:0] to [0:8] = '{32'h60402, 32'h60401, 32'h60402, 32'h60402, 32'h60402,
      32'h60402, 32'h60402, 32'h100800, 32'h60402};
   reg [15:0] tk [0:8] = '{16'hE005, 16'hE005, 16'hE105, 16'h7705, 16'h0009, 16'hF005,
      16'hF005, 16'hF805, 16'hF005};
   reg [3:0] te [0:8] = '{4'h6, 4'h2, 4'h7, 4'h1, 4'h8, 4'h3, 4'h5, 4'h4, 4'h4};
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      av(1, `SDIC_REG_STATUS, 0);
      chk("status", 32'h0, q);
      av(1, `SDIC_REG_CTL, 0);
      chk("ctl", 32'h0, q);
      av(1, `SDIC_REG_SETUP, 0);
      chk("setup", `SDIC_SETUP_RST, q);
      av(1, 5'h18, 0);
      chk("unmapped", 32'h0, q);
      $display("reset test done");
      av(0, `SDIC_REG_SETUP, 32'hE0);
      av(0, `SDIC_REG_OPND, 32'h60402);
      order(`SDIC_CMD_WR_CTL, 0, 32'h10);
      av(1, `SDIC_REG_CTL, 0);
      chk("ctl mirror", 32'h10, q);
      order(`SDIC_CMD_STEP_CNT, 0, 32'h50000);
      chk("count", 16'h5, mcnt);
      av(0, `SDIC_REG_CMD, 32'hE005);
      av(0, `SDIC_REG_CMD, 32'hE105);
      idle;
      chk("drawn", 8'h2, drawn);
      chk("left du", `SDIC_DU_LTR, last_du);
      order(`SDIC_CMD_DRAW, 8'hE0, 0);
      chk("zero count", 8'h2, drawn);
      av(0, `SDIC_REG_SETUP, 32'hF1);
      order(`SDIC_CMD_STEP_CNT, 0, 32'h30000);
      order(`SDIC_CMD_STEP_X, 0, 0);
      order(`SDIC_CMD_DRAW, 8'hE4, 0);
      chk("reset count", 16'h3, mcnt);
      chk("right du", `SDIC_DU_RTL, last_du);
      chk("accepted", 16'h8, q[31:16]);
      $display("parallel test done");
      for (int i = 0; i < 9; i++)
      begin
         order(`SDIC_CMD_WR_CTL, 0, tc[i]);
         av(0, `SDIC_REG_SETUP, ts[i]);
         av(0, `SDIC_REG_OPND, to[i]);
         av(1, `SDIC_REG_STATUS, 0);
         n0 = q;
         av(0, `SDIC_REG_CMD, tk[i]);
         idle;
         chk("error code", te[i], q[7:4]);
         chk("not issued", n0[31:16], q[31:16]);
      end
      $display("refusal test done");
      order(`SDIC_CMD_WR_CTL, 0, 32'h0);
      order(`SDIC_CMD_STEP_CNT, 0, 32'h30000);
      @(posedge clk);
      fw <= 4'h2;
      dr0 = drawn;
      order(`SDIC_CMD_DRAW, 8'hF1, 0);
      chk("repeat stall", 8, st_l);
      chk("param drawn", dr0 + 8'h1, drawn);
      @(posedge clk);
      fw <= 4'h0;
      order(`SDIC_CMD_STEP_CNT, 0, 32'hFFFF0000);
      order(`SDIC_CMD_DRAW, 8'hF0, 0);
      chk("single stall", 2, st_l);
      chk("negative count", dr0 + 8'h1, drawn);
      order(`SDIC_CMD_WR_CTL, 0, 32'h200);
      av(0, `SDIC_REG_OPND, 32'h100800);
      order(`SDIC_CMD_DRAW, 8'hF8, 0);
      chk("count kept", 16'hFFFF, mcnt);
      order(`SDIC_CMD_WR_CTL, 0, 32'h11);
      av(0, `SDIC_REG_OPND, 32'hC0804);
      order(`SDIC_CMD_STEP_Q, 0, 0);
      chk("seed set", 1, q[8]);
      n0 = q;
      order(`SDIC_CMD_DRAW, 8'hF2, 0);
      chk("seed used", 1, q[8] == 1'b0 && q[31:16] == n0[31:16] + 1);
      $display("parameterized test done");
      wrap_up;
   end
endmodule // sdic_issue_ctrl_tb
